// File: hw/srfu_pkg.sv
package srfu_pkg;

   // ------------------------------------------------------------
   // Register map, byte addresses on the register bus.
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_GPR_BASE = 8'h80;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [1:0] SEL_STATUS = 2'h0;
   localparam logic [1:0] SEL_CTRL = 2'h1;
   localparam logic [1:0] SEL_GPR = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;

   // ------------------------------------------------------------
   // Status flag positions and reset values.
   // ------------------------------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] GPR_RST = 8'h00;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;

   // ------------------------------------------------------------
   // Instructions handed over by the decoder.
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NOP,
      OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT_CARRY,
      OP_LOGICAL_SHIFT_RIGHT,
      OP_ARITH_SHIFT_RIGHT,
      OP_SWAP_NIBBLES,
      OP_FLAG_SET,
      OP_FLAG_CLEAR,
      OP_BIT_TO_TRANSFER_FLAG,
      OP_TRANSFER_FLAG_TO_BIT,
      OP_SET_OVERFLOW,
      OP_CLEAR_OVERFLOW,
      OP_SET_HALF_CARRY,
      OP_CLEAR_HALF_CARRY,
      OP_SET_SIGN_FLAG,
      OP_CLEAR_SIGN_FLAG,
      OP_SLEEP,
      OP_WATCHDOG_RESTART
   } srfu_op_e;

endpackage

// File: hw/srfu_exec.sv
`timescale 1ns/10ps
module srfu_exec (
   input wire srfu_pkg::srfu_op_e op,
   input wire logic [7:0] dstVal,
   input wire logic [7:0] srcVal,
   input wire logic [2:0] bitSel,
   input wire logic [7:0] flagsIn,
   output logic [7:0] result,
   output logic resWrite,
   output logic [7:0] flagsOut,
   output logic sleepHit,
   output logic restartHit
);

   // Shifts share one flag rule; overflow is negative xor carry.
   function automatic logic [7:0] shiftFlags(input logic [7:0] f,
      input logic [7:0] r, input logic c);
      logic [7:0] o;
      o = f;
      o[srfu_pkg::FLAG_C] = c;
      o[srfu_pkg::FLAG_Z] = (r == 8'h00);
      o[srfu_pkg::FLAG_N] = r[7];
      o[srfu_pkg::FLAG_V] = r[7] ^ c;
      return o;
   endfunction

   always_comb begin
      result = dstVal;
      resWrite = 1'b0;
      flagsOut = flagsIn;
      sleepHit = 1'b0;
      restartHit = 1'b0;
      unique case (op)
         srfu_pkg::OP_NOP: begin
         end
         srfu_pkg::OP_ROTATE_LEFT_CARRY: begin
            result = {dstVal[6:0], flagsIn[srfu_pkg::FLAG_C]};
            resWrite = 1'b1;
            flagsOut = shiftFlags(flagsIn, result, dstVal[7]);
         end
         srfu_pkg::OP_ROTATE_RIGHT_CARRY: begin
            result = {flagsIn[srfu_pkg::FLAG_C], dstVal[7:1]};
            resWrite = 1'b1;
            flagsOut = shiftFlags(flagsIn, result, dstVal[0]);
         end
         srfu_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
            result = {1'b0, dstVal[7:1]};
            resWrite = 1'b1;
            flagsOut = shiftFlags(flagsIn, result, dstVal[0]);
         end
         srfu_pkg::OP_ARITH_SHIFT_RIGHT: begin
            result = {dstVal[7], dstVal[7:1]};
            resWrite = 1'b1;
            flagsOut = shiftFlags(flagsIn, result, dstVal[0]);
         end
         srfu_pkg::OP_SWAP_NIBBLES: begin
            result = {dstVal[3:0], dstVal[7:4]};
            resWrite = 1'b1;
         end
         srfu_pkg::OP_FLAG_SET: flagsOut[bitSel] = 1'b1;
         srfu_pkg::OP_FLAG_CLEAR: flagsOut[bitSel] = 1'b0;
         srfu_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
            flagsOut[srfu_pkg::FLAG_T] = srcVal[bitSel];
         end
         srfu_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
            result[bitSel] = flagsIn[srfu_pkg::FLAG_T];
            resWrite = 1'b1;
         end
         srfu_pkg::OP_SET_OVERFLOW: flagsOut[srfu_pkg::FLAG_V] = 1'b1;
         srfu_pkg::OP_CLEAR_OVERFLOW: begin
            flagsOut[srfu_pkg::FLAG_V] = 1'b0;
         end
         srfu_pkg::OP_SET_HALF_CARRY: begin
            flagsOut[srfu_pkg::FLAG_H] = 1'b1;
         end
         srfu_pkg::OP_CLEAR_HALF_CARRY: begin
            flagsOut[srfu_pkg::FLAG_H] = 1'b0;
         end
         srfu_pkg::OP_SET_SIGN_FLAG: begin
            flagsOut[srfu_pkg::FLAG_S] = 1'b1;
         end
         srfu_pkg::OP_CLEAR_SIGN_FLAG: begin
            flagsOut[srfu_pkg::FLAG_S] = 1'b0;
         end
         srfu_pkg::OP_SLEEP: sleepHit = 1'b1;
         srfu_pkg::OP_WATCHDOG_RESTART: restartHit = 1'b1;
         default: begin
         end
      endcase
   end

endmodule

// File: hw/srfu_top.sv
`timescale 1ns/10ps
module srfu_top #(
   parameter int REG_CNT = 32
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic instValid,
   input wire srfu_pkg::srfu_op_e instOp,
   input wire logic [4:0] instRd,
   input wire logic [4:0] instRr,
   input wire logic [2:0] instBit,
   output logic [7:0] statusFlags,
   output logic sleepReq,
   output logic wdtRestart,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);

   if (REG_CNT != 32) begin : g_bad_cnt
      $error("REG_CNT must be 32 to fill the register window.");
   end

   // ------------------------------------------------------------
   // Register bus address decode.
   // ------------------------------------------------------------
   function automatic logic [1:0] decode(input logic [7:0] a);
      logic [1:0] s;
      s = srfu_pkg::SEL_NONE;
      if (a == srfu_pkg::ADDR_STATUS) begin
         s = srfu_pkg::SEL_STATUS;
      end else if (a == srfu_pkg::ADDR_CTRL) begin
         s = srfu_pkg::SEL_CTRL;
      end else if (a >= srfu_pkg::ADDR_GPR_BASE && a[1:0] == 2'h0) begin
         s = srfu_pkg::SEL_GPR;
      end
      return s;
   endfunction

   logic [7:0] gprR [REG_CNT];
   logic [7:0] gprNxt [REG_CNT];
   logic [7:0] flagReg_r;
   logic [7:0] flagReg_nxt;
   logic enable_r;
   logic enable_nxt;
   logic sleep_r;
   logic sleep_nxt;
   logic restart_r;
   logic restart_nxt;

   logic awHeld_r;
   logic awHeld_nxt;
   logic [7:0] awAddr_r;
   logic [7:0] awAddr_nxt;
   logic wHeld_r;
   logic wHeld_nxt;
   logic [7:0] wData_r;
   logic [7:0] wData_nxt;
   logic wLane_r;
   logic wLane_nxt;
   logic bvalid_r;
   logic bvalid_nxt;
   logic [1:0] bresp_r;
   logic [1:0] bresp_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_r;
   logic [1:0] rresp_nxt;

   logic instGo;
   logic [7:0] rdVal;
   logic [7:0] rrVal;
   logic [7:0] exResult;
   logic exWrite;
   logic [7:0] exFlags;
   logic exSleep;
   logic exRestart;
   logic doWrite;
   logic [1:0] wSel;
   logic [1:0] rSel;

   // An instruction only runs while software leaves the unit enabled.
   assign instGo = instValid && enable_r;
   assign rdVal = gprR[instRd];
   assign rrVal = gprR[instRr];

   srfu_exec u_exec (
      .op(instOp),
      .dstVal(rdVal),
      .srcVal(rrVal),
      .bitSel(instBit),
      .flagsIn(flagReg_r),
      .result(exResult),
      .resWrite(exWrite),
      .flagsOut(exFlags),
      .sleepHit(exSleep),
      .restartHit(exRestart)
   );

   // ------------------------------------------------------------
   // Register bus write and read channels.
   // ------------------------------------------------------------
   assign awready = !awHeld_r && !bvalid_r;
   assign wready = !wHeld_r && !bvalid_r;
   assign arready = !rvalid_r;
   assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
   assign wSel = decode(awAddr_r);
   assign rSel = decode(araddr);

   always_comb begin
      awHeld_nxt = awHeld_r;
      awAddr_nxt = awAddr_r;
      wHeld_nxt = wHeld_r;
      wData_nxt = wData_r;
      wLane_nxt = wLane_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (awvalid && awready) begin
         awHeld_nxt = 1'b1;
         awAddr_nxt = awaddr;
      end
      if (wvalid && wready) begin
         wHeld_nxt = 1'b1;
         wData_nxt = wdata[7:0];
         wLane_nxt = wstrb[0];
      end
      if (doWrite) begin
         awHeld_nxt = 1'b0;
         wHeld_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (wSel == srfu_pkg::SEL_NONE) ? srfu_pkg::RESP_SLVERR
                                                : srfu_pkg::RESP_OKAY;
      end else if (bvalid_r && bready) begin
         bvalid_nxt = 1'b0;
      end
   end

   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (arvalid && arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = srfu_pkg::RESP_OKAY;
         unique case (rSel)
            srfu_pkg::SEL_STATUS: rdata_nxt = {24'h00_0000, flagReg_r};
            srfu_pkg::SEL_CTRL: rdata_nxt = {31'h0000_0000, enable_r};
            srfu_pkg::SEL_GPR: begin
               rdata_nxt = {24'h00_0000, gprR[araddr[6:2]]};
            end
            srfu_pkg::SEL_NONE: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = srfu_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Register file, status flags and control.
   // ------------------------------------------------------------
   // An instruction overrides a bus write to the same target in the same
   // cycle, so the core never loses a result to a concurrent debug write.
   always_comb begin
      gprNxt = gprR;
      flagReg_nxt = flagReg_r;
      enable_nxt = enable_r;
      if (doWrite && wLane_r) begin
         if (wSel == srfu_pkg::SEL_GPR) begin
            gprNxt[awAddr_r[6:2]] = wData_r;
         end
         if (wSel == srfu_pkg::SEL_STATUS) begin
            flagReg_nxt = wData_r;
         end
         if (wSel == srfu_pkg::SEL_CTRL) begin
            enable_nxt = wData_r[srfu_pkg::CTRL_EN_BIT];
         end
      end
      if (instGo) begin
         flagReg_nxt = exFlags;
         if (exWrite) begin
            gprNxt[instRd] = exResult;
         end
      end
   end

   always_comb begin
      sleep_nxt = instGo && exSleep;
      restart_nxt = instGo && exRestart;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < REG_CNT; i++) begin
            gprR[i] <= srfu_pkg::GPR_RST;
         end
         flagReg_r <= srfu_pkg::STATUS_RST;
         enable_r <= srfu_pkg::CTRL_EN_RST;
         sleep_r <= 1'b0;
         restart_r <= 1'b0;
         awHeld_r <= 1'b0;
         awAddr_r <= 8'h00;
         wHeld_r <= 1'b0;
         wData_r <= 8'h00;
         wLane_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= srfu_pkg::RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= srfu_pkg::RESP_OKAY;
      end else begin
         gprR <= gprNxt;
         flagReg_r <= flagReg_nxt;
         enable_r <= enable_nxt;
         sleep_r <= sleep_nxt;
         restart_r <= restart_nxt;
         awHeld_r <= awHeld_nxt;
         awAddr_r <= awAddr_nxt;
         wHeld_r <= wHeld_nxt;
         wData_r <= wData_nxt;
         wLane_r <= wLane_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign statusFlags = flagReg_r;
   assign sleepReq = sleep_r;
   assign wdtRestart = restart_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   logic [7:0] prevRd_r;
   logic [7:0] prevFlags_r;
   logic [4:0] prevIdx_r;
   logic [2:0] prevBit_r;
   logic prevSrcBit_r;

   always_ff @(posedge core_clk) begin
      prevRd_r <= rdVal;
      prevFlags_r <= flagReg_r;
      prevIdx_r <= instRd;
      prevBit_r <= instBit;
      prevSrcBit_r <= rrVal[instBit];
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_go(srfu_pkg::srfu_op_e o);
      instGo && instOp == o;
   endsequence

   sequence s_flags_only(logic [7:0] m, logic v);
      (flagReg_r & ~m) == (prevFlags_r & ~m)
         && ((flagReg_r & m) != 8'h00) == v;
   endsequence

   property p_rotl;
      s_go(srfu_pkg::OP_ROTATE_LEFT_CARRY) |=>
         gprR[prevIdx_r] == {prevRd_r[6:0], prevFlags_r[srfu_pkg::FLAG_C]}
         && flagReg_r[srfu_pkg::FLAG_C] == prevRd_r[7]
         && flagReg_r[srfu_pkg::FLAG_V] == (prevRd_r[6] ^ prevRd_r[7]);
   endproperty
   a_rotl: assert property (p_rotl) else $error("rotate left wrong");

   property p_rotr;
      s_go(srfu_pkg::OP_ROTATE_RIGHT_CARRY) |=>
         gprR[prevIdx_r] == {prevFlags_r[srfu_pkg::FLAG_C], prevRd_r[7:1]}
         && flagReg_r[srfu_pkg::FLAG_C] == prevRd_r[0]
         && flagReg_r[srfu_pkg::FLAG_Z] == (gprR[prevIdx_r] == 8'h00);
   endproperty
   a_rotr: assert property (p_rotr) else $error("rotate right bad");

   property p_bitToT;
      s_go(srfu_pkg::OP_BIT_TO_TRANSFER_FLAG) |=>
         flagReg_r[srfu_pkg::FLAG_T] == prevSrcBit_r
         && flagReg_r[5:0] == prevFlags_r[5:0];
   endproperty
   a_bitToT: assert property (p_bitToT) else $error("bit store bad");

   property p_tToBit;
      s_go(srfu_pkg::OP_TRANSFER_FLAG_TO_BIT) |=>
         gprR[prevIdx_r][prevBit_r] == prevFlags_r[srfu_pkg::FLAG_T]
         && flagReg_r == prevFlags_r;
   endproperty
   a_tToBit: assert property (p_tToBit) else $error("bit load bad");

   property p_setOvf;
      s_go(srfu_pkg::OP_SET_OVERFLOW) |=> s_flags_only(8'h08, 1'b1);
   endproperty
   a_setOvf: assert property (p_setOvf) else $error("set ovf bad");

   property p_clrOvf;
      s_go(srfu_pkg::OP_CLEAR_OVERFLOW) |=> s_flags_only(8'h08, 1'b0);
   endproperty
   a_clrOvf: assert property (p_clrOvf) else $error("clr ovf bad");

   property p_setHalf;
      s_go(srfu_pkg::OP_SET_HALF_CARRY) |=> s_flags_only(8'h20, 1'b1);
   endproperty
   a_setHalf: assert property (p_setHalf) else $error("set h bad");

   property p_clrHalf;
      s_go(srfu_pkg::OP_CLEAR_HALF_CARRY) |=> s_flags_only(8'h20, 1'b0);
   endproperty
   a_clrHalf: assert property (p_clrHalf) else $error("clr h bad");

   property p_setSign;
      s_go(srfu_pkg::OP_SET_SIGN_FLAG) |=> s_flags_only(8'h10, 1'b1);
   endproperty
   a_setSign: assert property (p_setSign) else $error("set s bad");

   property p_clrSign;
      s_go(srfu_pkg::OP_CLEAR_SIGN_FLAG) |=> s_flags_only(8'h10, 1'b0);
   endproperty
   a_clrSign: assert property (p_clrSign) else $error("clr s bad");

   property p_sleep;
      s_go(srfu_pkg::OP_SLEEP) |=> sleepReq && flagReg_r == prevFlags_r;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep wrong");

   property p_sleepOnce;
      sleepReq |-> $past(instGo) && $past(instOp) == srfu_pkg::OP_SLEEP;
   endproperty
   a_sleepOnce: assert property (p_sleepOnce) else $error("stray sleep");

   property p_wdogRestart;
      s_go(srfu_pkg::OP_WATCHDOG_RESTART) |=>
         wdtRestart && flagReg_r == prevFlags_r;
   endproperty
   a_wdogRestart: assert property (p_wdogRestart) else $error("wdt bad");

   property p_lshr;
      s_go(srfu_pkg::OP_LOGICAL_SHIFT_RIGHT) |=>
         gprR[prevIdx_r] == {1'b0, prevRd_r[7:1]}
         && flagReg_r[srfu_pkg::FLAG_C] == prevRd_r[0]
         && !flagReg_r[srfu_pkg::FLAG_N];
   endproperty
   a_lshr: assert property (p_lshr) else $error("logical shift bad");

   property p_ashr;
      s_go(srfu_pkg::OP_ARITH_SHIFT_RIGHT) |=>
         gprR[prevIdx_r] == {prevRd_r[7], prevRd_r[7:1]}
         && flagReg_r[srfu_pkg::FLAG_C] == prevRd_r[0];
   endproperty
   a_ashr: assert property (p_ashr) else $error("arith shift bad");

   property p_swap;
      s_go(srfu_pkg::OP_SWAP_NIBBLES) |=>
         gprR[prevIdx_r] == {prevRd_r[3:0], prevRd_r[7:4]}
         && flagReg_r == prevFlags_r;
   endproperty
   a_swap: assert property (p_swap) else $error("swap wrong");

   property p_bset;
      s_go(srfu_pkg::OP_FLAG_SET) |=> flagReg_r[prevBit_r]
         and s_flags_only(8'h01 << prevBit_r, 1'b1);
   endproperty
   a_bset: assert property (p_bset) else $error("flag set wrong");

endmodule

// File: test/tb.sv
`timescale 1ns/10ps
module tb;
   // ------------------------------------------------------------
   // Signals and design instance.
   // ------------------------------------------------------------
   localparam logic [1:0] OK = srfu_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = srfu_pkg::RESP_SLVERR;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic instValid = 1'b0;
   srfu_pkg::srfu_op_e instOp = srfu_pkg::OP_NOP;
   logic [4:0] instRd = 5'h0;
   logic [4:0] instRr = 5'h0;
   logic [2:0] instBit = 3'h0;
   logic [7:0] statusFlags;
   logic sleepReq;
   logic wdtRestart;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hf;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   int failCount = 0;
   int checks = 0;
   int cycles = 0;

   srfu_top #(.REG_CNT(32)) i_srfu_top (.core_clk(core_clk), .rst(rst),
      .instValid(instValid), .instOp(instOp), .instRd(instRd),
      .instRr(instRr), .instBit(instBit), .statusFlags(statusFlags),
      .sleepReq(sleepReq), .wdtRestart(wdtRestart), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));

   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   // A hung handshake would otherwise stall the run for ever.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failCount++;
         completeRun();
      end
   end

   // ------------------------------------------------------------
   // Shared tasks.
   // ------------------------------------------------------------
   task automatic completeRun();
      $display("checks %0d mismatches %0d", checks, failCount);
      if (failCount == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failCount++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] ga(input logic [4:0] i);
      return srfu_pkg::ADDR_GPR_BASE + {1'b0, i, 2'b00};
   endfunction

   // Ready is sampled at the edge itself, before the slave's flops move.
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
      logic awPend;
      logic wPend;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      awPend = 1'b1;
      wPend = 1'b1;
      while (awPend || wPend) begin
         @(posedge core_clk);
         if (awPend && awready === 1'b1) begin
            awPend = 1'b0;
            awvalid <= 1'b0;
         end
         if (wPend && wready === 1'b1) begin
            wPend = 1'b0;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) begin
         @(posedge core_clk);
      end
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) begin
         @(posedge core_clk);
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      axiWrite(a, {24'h00_0000, d}, 4'hf, r);
      check(32'(r), 32'(OK));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      axiRead(a, d, r);
      check(d, e);
      check(32'(r), 32'(er));
   endtask

   task automatic exec(input srfu_pkg::srfu_op_e op, input logic [4:0] idx,
      input logic [2:0] bt);
      @(posedge core_clk);
      instOp <= op;
      instRd <= idx;
      instRr <= idx;
      instBit <= bt;
      instValid <= 1'b1;
      @(posedge core_clk);
      instValid <= 1'b0;
      #1;
   endtask

   task automatic runCase(input srfu_pkg::srfu_op_e op, input logic [4:0] idx,
      input logic [2:0] bt, input logic [7:0] rv, input logic [7:0] st,
      input logic [7:0] er, input logic [7:0] ef);
      wr(ga(idx), rv);
      wr(srfu_pkg::ADDR_STATUS, st);
      exec(op, idx, bt);
      check(32'(statusFlags), 32'(ef));
      rd(ga(idx), 32'(er), OK);
   endtask

   task automatic pulseCase(input srfu_pkg::srfu_op_e op, input logic es,
      input logic ew);
      wr(srfu_pkg::ADDR_STATUS, 8'h5a);
      exec(op, 5'h0, 3'h0);
      check({30'h0000_0000, sleepReq, wdtRestart}, {30'h0000_0000, es, ew});
      check(32'(statusFlags), 32'h0000_005a);
      @(posedge core_clk);
      #1;
      check({30'h0000_0000, sleepReq, wdtRestart}, 32'h0000_0000);
   endtask

   // ------------------------------------------------------------
   // Test sequence.
   // ------------------------------------------------------------
   initial begin
      logic [1:0] r;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      rd(srfu_pkg::ADDR_STATUS, 32'h0000_0000, OK);
      rd(srfu_pkg::ADDR_CTRL, 32'h0000_0001, OK);
      rd(ga(5'h1f), 32'h0000_0000, OK);
      rd(8'h08, 32'h0000_0000, ERR);
      axiWrite(8'h0c, 32'h0000_00ff, 4'hf, r);
      check(32'(r), 32'(ERR));
      axiWrite(ga(5'h0), 32'h0000_00ff, 4'h0, r);
      check(32'(r), 32'(OK));
      rd(ga(5'h0), 32'h0000_0000, OK);
      runCase(srfu_pkg::OP_ROTATE_LEFT_CARRY, 5'h3, 3'h0,
         8'h81, 8'h7d, 8'h03, 8'h79);
      runCase(srfu_pkg::OP_ROTATE_LEFT_CARRY, 5'h3, 3'h0,
         8'h00, 8'h7c, 8'h00, 8'h72);
      runCase(srfu_pkg::OP_ROTATE_RIGHT_CARRY, 5'h4, 3'h0,
         8'h02, 8'h7d, 8'h81, 8'h7c);
      runCase(srfu_pkg::OP_ROTATE_RIGHT_CARRY, 5'h4, 3'h0,
         8'h01, 8'h7c, 8'h00, 8'h7b);
      runCase(srfu_pkg::OP_LOGICAL_SHIFT_RIGHT, 5'h9, 3'h0,
         8'h81, 8'h7d, 8'h40, 8'h79);
      runCase(srfu_pkg::OP_ARITH_SHIFT_RIGHT, 5'h9, 3'h0,
         8'h81, 8'h7c, 8'hc0, 8'h75);
      runCase(srfu_pkg::OP_ARITH_SHIFT_RIGHT, 5'h9, 3'h0,
         8'h40, 8'h7d, 8'h20, 8'h70);
      runCase(srfu_pkg::OP_SWAP_NIBBLES, 5'h8, 3'h0,
         8'h3c, 8'h5a, 8'hc3, 8'h5a);
      runCase(srfu_pkg::OP_BIT_TO_TRANSFER_FLAG, 5'h5, 3'h5,
         8'h20, 8'hbf, 8'h20, 8'hff);
      runCase(srfu_pkg::OP_BIT_TO_TRANSFER_FLAG, 5'h5, 3'h4,
         8'h20, 8'hff, 8'h20, 8'hbf);
      runCase(srfu_pkg::OP_TRANSFER_FLAG_TO_BIT, 5'h6, 3'h7,
         8'h00, 8'h40, 8'h80, 8'h40);
      runCase(srfu_pkg::OP_TRANSFER_FLAG_TO_BIT, 5'h6, 3'h0,
         8'hff, 8'hbf, 8'hfe, 8'hbf);
      runCase(srfu_pkg::OP_SET_OVERFLOW, 5'h7, 3'h0,
         8'ha5, 8'ha5, 8'ha5, 8'had);
      runCase(srfu_pkg::OP_CLEAR_OVERFLOW, 5'h7, 3'h0,
         8'ha5, 8'h5a, 8'ha5, 8'h52);
      runCase(srfu_pkg::OP_SET_HALF_CARRY, 5'h7, 3'h0,
         8'ha5, 8'h85, 8'ha5, 8'ha5);
      runCase(srfu_pkg::OP_CLEAR_HALF_CARRY, 5'h7, 3'h0,
         8'ha5, 8'h7a, 8'ha5, 8'h5a);
      runCase(srfu_pkg::OP_SET_SIGN_FLAG, 5'h7, 3'h0,
         8'ha5, 8'ha5, 8'ha5, 8'hb5);
      runCase(srfu_pkg::OP_CLEAR_SIGN_FLAG, 5'h7, 3'h0,
         8'ha5, 8'h5a, 8'ha5, 8'h4a);
      for (int b = 0; b < 8; b++) begin
         runCase(srfu_pkg::OP_FLAG_SET, 5'h7, 3'(b),
            8'h3c, 8'h00, 8'h3c, 8'(1 << b));
         runCase(srfu_pkg::OP_FLAG_CLEAR, 5'h7, 3'(b),
            8'h3c, 8'hff, 8'h3c, ~8'(1 << b));
      end
      pulseCase(srfu_pkg::OP_SLEEP, 1'b1, 1'b0);
      pulseCase(srfu_pkg::OP_WATCHDOG_RESTART, 1'b0, 1'b1);
      pulseCase(srfu_pkg::OP_NOP, 1'b0, 1'b0);
      // Two rotates back to back: the second must see the first's carry.
      wr(ga(5'h3), 8'h80);
      wr(srfu_pkg::ADDR_STATUS, 8'h00);
      @(posedge core_clk);
      instOp <= srfu_pkg::OP_ROTATE_LEFT_CARRY;
      instRd <= 5'h3;
      instValid <= 1'b1;
      repeat (2) @(posedge core_clk);
      instValid <= 1'b0;
      #1;
      check(32'(statusFlags), 32'h0000_0000);
      rd(ga(5'h3), 32'h0000_0001, OK);
      wr(srfu_pkg::ADDR_CTRL, 8'h00);
      rd(srfu_pkg::ADDR_CTRL, 32'h0000_0000, OK);
      exec(srfu_pkg::OP_SET_OVERFLOW, 5'h3, 3'h0);
      check(32'(statusFlags), 32'h0000_0000);
      wr(srfu_pkg::ADDR_CTRL, 8'h01);
      completeRun();
   end
endmodule
